// ===== design/ssga_pkg.sv
/*
  Shared constants for the serializer side-band block: register offsets,
  field positions, pin codes and link timing.
  Assumes a 100 MHz pixel-rate clock on both ends of the link.
*/
package ssga_pkg;
  // Register offsets and register reset value
  localparam logic [7:0] OFF_MODE     = 8'h04;
  localparam logic [7:0] OFF_PIN0     = 8'h0d;
  localparam logic [7:0] OFF_PIN12    = 8'h0e;
  localparam logic [7:0] OFF_PIN35    = 8'h0f;
  localparam logic [7:0] OFF_PIN67    = 8'h10;
  localparam logic [7:0] OFF_PIN8     = 8'h11;
  localparam logic [7:0] OFF_VWIDTH   = 8'h12;
  localparam logic [7:0] OFF_IN_LO    = 8'h1c;
  localparam logic [7:0] OFF_IN_HI    = 8'h1d;
  localparam logic [7:0] OFF_IRQ_CTL  = 8'hc6;
  localparam logic [7:0] OFF_IRQ_STAT = 8'hc7;
  localparam logic [7:0] REG_RST      = 8'h00;

  // Mode, video width, interrupt control and status register fields
  localparam int MODE_LF        = 0;
  localparam int MODE_LEGACY    = 1;
  localparam int MODE_NO_ISLAND = 2;
  localparam int MODE_SURROUND  = 3;
  localparam int MODE_AB4       = 4;
  localparam int MODE_REPEATER  = 5;
  localparam int MODE_REGEN     = 6;
  localparam int MODE_OLDER     = 7;
  localparam int VW_18BIT       = 2;
  localparam int IRQ_EN_HI      = 5;
  localparam int IRQ_EN_LO      = 0;
  localparam int STAT_PEND      = 0;
  localparam int STAT_LEVEL     = 1;

  // Pin configuration nibble codes
  localparam logic [3:0] CODE_LOW   = 4'h1;
  localparam logic [3:0] CODE_HIGH  = 4'h9;
  localparam logic [3:0] CODE_INPUT = 4'h3;
  localparam logic [3:0] CODE_RELAY = 4'h5;

  // Serial line rate ratio
  localparam logic [2:0] RATE_NORMAL = 3'h1;
  localparam logic [2:0] RATE_LF     = 3'h4;

  // Back channel timing
  localparam int CLK_MHZ       = 100;
  localparam int BC_RATE_MBPS  = 10;
  localparam int BC_BIT_CYCLES = CLK_MHZ / BC_RATE_MBPS;

  // Audio word layout: {island, channel, lane mask, 4 lanes}
  localparam int AUD_W_DEF = 24;
  localparam int FW_DEF    = 6 + 4 * AUD_W_DEF;
endpackage

// ===== design/ssga_link_if.sv
/*
  Serial link between the serializer end and the paired deserializer end.
  Assumes both ends share one clock; the testbench joins the two modports.
*/
`timescale 1ns/1ns
interface ssga_link_if #(
  parameter int FW = ssga_pkg::FW_DEF
);
  logic [3:0]    fwd_gpio;
  logic          cfg_18bit;
  logic [3:0]    bc_gpio;
  logic          bc_irq_n;
  logic          bc_surround;
  logic          ctl_req;
  logic          ctl_we;
  logic [7:0]    ctl_addr;
  logic [7:0]    ctl_wdata;
  logic          ctl_ack;
  logic [7:0]    ctl_rdata;
  logic          aud_valid;
  logic          aud_ready;
  logic [FW-1:0] aud_data;

  modport ser (
    output fwd_gpio, cfg_18bit, ctl_ack, ctl_rdata, aud_valid, aud_data,
    input  bc_gpio, bc_irq_n, bc_surround, ctl_req, ctl_we, ctl_addr, ctl_wdata, aud_ready
  );
  modport des (
    input  fwd_gpio, cfg_18bit, ctl_ack, ctl_rdata, aud_valid, aud_data,
    output bc_gpio, bc_irq_n, bc_surround, ctl_req, ctl_we, ctl_addr, ctl_wdata, aud_ready
  );
endinterface

// ===== design/ssga_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock; full and empty come straight from the fill count.
*/
`timescale 1ns/1ns
module ssga_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0]   cnt_reg;
  logic          push;
  logic          pop;

  assign in_ready_o  = (cnt_reg != FULL);
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem[rptr_reg];
  assign push = in_valid_i & in_ready_o;
  assign pop  = out_valid_o & out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg  <= '0;
    end else begin
      if (push) begin
        wptr_reg <= (wptr_reg == LAST) ? '0 : wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= (rptr_reg == LAST) ? '0 : rptr_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ===== design/ssga_ser.sv
/*
  Serializer end: mode capture, interrupt relay, link and register-only
  pins, audio capture and transport selection, register access.
  Assumes register requests are held until acknowledged, and that pins,
  straps and the audio bit clock arrive unsynchronised.
*/
// Overview of operation
// - Source keeps pixel clock in mode range
// - Low-frequency mode applies after power-down reset
// - Low-frequency mode quadruples line rate, except legacy
// - Host sets two control bits to enable interrupt
// - First status read arms the interrupt
// - Remote interrupt low pulls output low
// - Status read clears and re-arms interrupt
// - Four link pins; pins 3:2 share audio pads
// - Older partner needs 18-bit mode, sent across
// - Link pin codes: 3 forward, 5 back
// - Remote uses complementary codes per pin
// - Local codes drive low, high, or input
// - Register-only pins override shared audio inputs
// - Register-only pin config and readback offsets
// - Register-only pins never cross the link
// - Audio bit clock kept within range
// - Four stereo audio lanes; none in legacy
// - Older partner: lane A, or A,B
// - Island transport default; frame mode limits lanes
// - Surround only island and newer partner
// - Remote surround command configures downstream
// - Repeater may regenerate audio from pins
// - Back channel carries pin state at 10 Mbps
// - Legacy disables channel, link pins, audio, interrupt
`timescale 1ns/1ns
module ssga_ser #(
  parameter int AUD_W      = ssga_pkg::AUD_W_DEF,
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  ssga_link_if.ser        lk,
  input  wire logic       power_down_n_i,
  input  wire logic       low_freq_mode_i,
  input  wire logic       legacy_compat_mode_i,
  input  wire logic       reg_req_i,
  input  wire logic       reg_we_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic            reg_ack_o,
  output logic [7:0]      reg_rdata_o,
  input  wire logic [7:0] pin_in_i,
  output logic [7:0]      pin_out_o,
  output logic [7:0]      pin_oe_o,
  input  wire logic       audio_bclk_i,
  input  wire logic       audio_word_select_i,
  input  wire logic       audio_data_a_i,
  input  wire logic       audio_data_b_i,
  input  wire logic       audio_data_c_i,
  input  wire logic       audio_data_d_i,
  output logic            audio_ready_o,
  output logic            irq_out_n_o,
  output logic [2:0]      line_rate_mult_o
);
  localparam int FW = 6 + 4 * AUD_W;
  localparam logic [7:0] REG_RST_C = ssga_pkg::REG_RST;

  logic [16:0] s1_reg;
  logic [16:0] s2_reg;
  logic [7:0]  pin_s;
  logic [3:0]  aud_s;
  logic        pd_n;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= {power_down_n_i, low_freq_mode_i, legacy_compat_mode_i, audio_bclk_i,
                 audio_word_select_i, audio_data_d_i, audio_data_c_i, audio_data_b_i,
                 audio_data_a_i, pin_in_i};
      s2_reg <= s1_reg;
    end
  end
  assign pin_s = s2_reg[7:0];
  assign aud_s = s2_reg[11:8];
  assign pd_n  = s2_reg[16];

  logic [7:0]      mode_reg;
  logic [4:0][7:0] pcfg_reg;
  logic [7:0]      vw_reg;
  logic [7:0]      ictl_reg;
  logic            lf_eff_reg;
  logic            leg_eff_reg;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lf_eff_reg  <= 1'b0;
      leg_eff_reg <= 1'b0;
    end else if (!pd_n) begin
      lf_eff_reg  <= s2_reg[15] | mode_reg[ssga_pkg::MODE_LF];
      leg_eff_reg <= s2_reg[14] | mode_reg[ssga_pkg::MODE_LEGACY];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      line_rate_mult_o <= ssga_pkg::RATE_NORMAL;
    end else begin
      line_rate_mult_o <= (lf_eff_reg & ~leg_eff_reg) ? ssga_pkg::RATE_LF : ssga_pkg::RATE_NORMAL;
    end
  end

  logic       loc_take;
  logic       rem_take;
  logic       rem_ok;
  logic       take;
  logic       we;
  logic       wr;
  logic       rd_stat;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rd_val;
  logic       ctl_ack_reg;
  logic       pend_reg;
  logic       armed_reg;
  logic       rirq_prev_reg;

  assign loc_take = reg_req_i & ~reg_ack_o;
  assign rem_take = lk.ctl_req & ~ctl_ack_reg & ~loc_take;
  assign rem_ok   = rem_take & ~leg_eff_reg;
  assign take     = loc_take | rem_ok;
  assign we       = loc_take ? reg_we_i : lk.ctl_we;
  assign addr     = loc_take ? reg_addr_i : lk.ctl_addr;
  assign wdata    = loc_take ? reg_wdata_i : lk.ctl_wdata;
  assign wr       = take & we & pd_n;
  assign rd_stat  = take & ~we & (addr == ssga_pkg::OFF_IRQ_STAT);
  assign lk.ctl_ack = ctl_ack_reg;

  // Mode register survives power-down so a new mode can take effect through it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_reg <= REG_RST_C;
    end else if (wr && addr == ssga_pkg::OFF_MODE) begin
      mode_reg <= wdata;
    end
  end

  always_comb begin
    rd_val = 8'h00;
    case (addr)
      ssga_pkg::OFF_MODE:     rd_val = mode_reg;
      ssga_pkg::OFF_PIN0:     rd_val = pcfg_reg[0];
      ssga_pkg::OFF_PIN12:    rd_val = pcfg_reg[1];
      ssga_pkg::OFF_PIN35:    rd_val = pcfg_reg[2];
      ssga_pkg::OFF_PIN67:    rd_val = pcfg_reg[3];
      ssga_pkg::OFF_PIN8:     rd_val = pcfg_reg[4];
      ssga_pkg::OFF_VWIDTH:   rd_val = vw_reg;
      ssga_pkg::OFF_IN_LO:    rd_val = {pin_s[6:4], 1'b0, pin_s[3:0]};
      ssga_pkg::OFF_IN_HI:    rd_val = {7'h00, pin_s[7]};
      ssga_pkg::OFF_IRQ_CTL:  rd_val = ictl_reg;
      ssga_pkg::OFF_IRQ_STAT: rd_val = {6'h00, ~lk.bc_irq_n, pend_reg};
      default:                rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_ack_o    <= 1'b0;
      reg_rdata_o  <= 8'h00;
      ctl_ack_reg  <= 1'b0;
      lk.ctl_rdata <= 8'h00;
    end else begin
      reg_ack_o   <= loc_take;
      ctl_ack_reg <= rem_take;
      if (loc_take) begin
        reg_rdata_o <= we ? 8'h00 : rd_val;
      end
      if (rem_take) begin
        lk.ctl_rdata <= (rem_ok & ~we) ? rd_val : 8'h00;
      end
    end
  end

  // Power-down clears every configuration register except the mode register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pcfg_reg <= '0;
      vw_reg   <= REG_RST_C;
      ictl_reg <= REG_RST_C;
    end else if (!pd_n) begin
      pcfg_reg <= '0;
      vw_reg   <= REG_RST_C;
      ictl_reg <= REG_RST_C;
    end else if (wr) begin
      case (addr)
        ssga_pkg::OFF_PIN0:    pcfg_reg[0] <= wdata;
        ssga_pkg::OFF_PIN12:   pcfg_reg[1] <= wdata;
        ssga_pkg::OFF_PIN35:   pcfg_reg[2] <= wdata;
        ssga_pkg::OFF_PIN67:   pcfg_reg[3] <= wdata;
        ssga_pkg::OFF_PIN8:    pcfg_reg[4] <= wdata;
        ssga_pkg::OFF_VWIDTH:  vw_reg      <= wdata;
        ssga_pkg::OFF_IRQ_CTL: ictl_reg    <= wdata;
        default:               ;
      endcase
    end
  end

  logic irq_en;
  logic irq_set;
  assign irq_en  = ictl_reg[ssga_pkg::IRQ_EN_HI] & ictl_reg[ssga_pkg::IRQ_EN_LO] & ~leg_eff_reg;
  assign irq_set = rirq_prev_reg & ~lk.bc_irq_n & armed_reg & irq_en;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rirq_prev_reg <= 1'b1;
      armed_reg     <= 1'b0;
      pend_reg      <= 1'b0;
      irq_out_n_o   <= 1'b1;
    end else begin
      rirq_prev_reg <= lk.bc_irq_n;
      if (!pd_n) begin
        armed_reg <= 1'b0;
        pend_reg  <= 1'b0;
        irq_out_n_o <= 1'b1;
      end else begin
        if (rd_stat) begin
          armed_reg <= 1'b1;
        end
        pend_reg    <= irq_set | (pend_reg & ~rd_stat);
        irq_out_n_o <= ~(irq_set | (pend_reg & ~rd_stat));
      end
    end
  end

  logic        link_ok;
  logic [39:0] pflat;
  wire  [7:0]  oe_c;
  wire  [7:0]  out_c;
  wire  [7:0]  act_c;
  wire  [3:0]  fwd_c;

  assign link_ok = ~leg_eff_reg & (~mode_reg[ssga_pkg::MODE_OLDER] | vw_reg[ssga_pkg::VW_18BIT]);
  assign pflat   = pcfg_reg;

  // Pin p uses nibble p+1 (pin 0 uses nibble 0), skipping the unused upper half of the first register
  for (genvar p = 0; p < 8; p++) begin : g_pin
    localparam int N = (p == 0) ? 0 : p + 1;
    localparam bit LINK = (p < 4);
    wire [3:0] code = pflat[4*N +: 4];
    wire       ok   = LINK ? link_ok : 1'b1;
    assign oe_c[p]  = ok & ((code == ssga_pkg::CODE_LOW) | (code == ssga_pkg::CODE_HIGH) |
                            (LINK & (code == ssga_pkg::CODE_RELAY)));
    assign out_c[p] = ok & ((code == ssga_pkg::CODE_HIGH) |
                            (LINK & (code == ssga_pkg::CODE_RELAY) & lk.bc_gpio[p % 4]));
    assign act_c[p] = oe_c[p] | (ok & (code == ssga_pkg::CODE_INPUT));
    if (LINK) begin : g_fwd
      assign fwd_c[p] = ok & (code == ssga_pkg::CODE_INPUT) & pin_s[p];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_out_o    <= 8'h00;
      pin_oe_o     <= 8'h00;
      lk.fwd_gpio  <= 4'h0;
      lk.cfg_18bit <= 1'b0;
    end else begin
      pin_out_o    <= out_c;
      pin_oe_o     <= oe_c;
      lk.fwd_gpio  <= fwd_c;
      lk.cfg_18bit <= vw_reg[ssga_pkg::VW_18BIT];
    end
  end

  logic             older;
  logic             island;
  logic             surround;
  logic [3:0]       lane_sel;
  logic [3:0]       claim;
  logic [3:0]       lane_en;
  logic             src_ok;
  logic [3:0][AUD_W-1:0] sh_reg;
  logic             bclk_prev_reg;
  logic             ws_prev_reg;
  logic             rise;
  logic             push;

  assign older    = mode_reg[ssga_pkg::MODE_OLDER];
  assign island   = ~mode_reg[ssga_pkg::MODE_NO_ISLAND];
  assign surround = (mode_reg[ssga_pkg::MODE_SURROUND] | lk.bc_surround) & island & ~older;

  always_comb begin
    if (older) begin
      lane_sel = vw_reg[ssga_pkg::VW_18BIT] ? 4'h3 : 4'h1;
    end else if (island && surround) begin
      lane_sel = 4'hf;
    end else if (island && mode_reg[ssga_pkg::MODE_AB4]) begin
      lane_sel = 4'h3;
    end else begin
      lane_sel = 4'h1;
    end
  end

  assign claim   = {act_c[7] | act_c[3], act_c[6] | act_c[2], act_c[5], act_c[4]};
  assign src_ok  = ~leg_eff_reg & (~mode_reg[ssga_pkg::MODE_REPEATER] | mode_reg[ssga_pkg::MODE_REGEN]);
  assign lane_en = src_ok ? (lane_sel & ~claim) : 4'h0;
  assign rise    = s2_reg[13] & ~bclk_prev_reg;
  // Source cannot stall: a word offered while full is lost, seen on audio_ready_o
  assign push    = rise & (s2_reg[12] != ws_prev_reg) & (|lane_en) & pd_n;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bclk_prev_reg <= 1'b0;
      ws_prev_reg   <= 1'b0;
      sh_reg        <= '0;
    end else begin
      bclk_prev_reg <= s2_reg[13];
      if (rise) begin
        ws_prev_reg <= s2_reg[12];
        for (int l = 0; l < 4; l++) begin
          sh_reg[l] <= {sh_reg[l][AUD_W-2:0], aud_s[l]};
        end
      end
    end
  end

  ssga_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (push),
    .in_ready_o  (audio_ready_o),
    .in_data_i   ({island, ws_prev_reg, lane_en, sh_reg}),
    .out_valid_o (lk.aud_valid),
    .out_ready_i (lk.aud_ready),
    .out_data_o  (lk.aud_data)
  );
endmodule

// ===== design/ssga_des.sv
/*
  Deserializer end of the link: complementary pin relay, back channel
  at the slow line rate, interrupt and surround forwarding, control
  channel master and audio sink.
  Assumes the same clock as the serializer end.
*/
`timescale 1ns/1ns
module ssga_des #(
  parameter int FW = ssga_pkg::FW_DEF
) (
  input  wire logic          clk_i,
  input  wire logic          resetn_i,
  ssga_link_if.des           lk,
  input  wire logic [15:0]   pin_cfg_i,
  input  wire logic [3:0]    pin_in_i,
  output logic [3:0]         pin_out_o,
  output logic [3:0]         pin_oe_o,
  input  wire logic          remote_irq_in_n_i,
  input  wire logic          surround_i,
  input  wire logic          host_req_i,
  input  wire logic          host_we_i,
  input  wire logic [7:0]    host_addr_i,
  input  wire logic [7:0]    host_wdata_i,
  output logic               host_ack_o,
  output logic [7:0]         host_rdata_o,
  output logic               aud_valid_o,
  input  wire logic          aud_ready_i,
  output logic [FW-1:0]      aud_word_o,
  output logic               cfg_18bit_o
);
  localparam logic [7:0] BC_LAST = 8'(ssga_pkg::BC_BIT_CYCLES - 1);

  logic [4:0] s1_reg;
  logic [4:0] s2_reg;
  logic [7:0] bc_cnt_reg;
  logic       tick;
  wire  [3:0] bc_c;
  wire  [3:0] oe_c;
  wire  [3:0] out_c;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_reg <= 5'h10;
      s2_reg <= 5'h10;
    end else begin
      s1_reg <= {remote_irq_in_n_i, pin_in_i};
      s2_reg <= s1_reg;
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_pin
    wire [3:0] code = pin_cfg_i[4*g +: 4];
    assign bc_c[g]  = (code == ssga_pkg::CODE_INPUT) & s2_reg[g];
    assign oe_c[g]  = (code == ssga_pkg::CODE_RELAY);
    assign out_c[g] = (code == ssga_pkg::CODE_RELAY) & lk.fwd_gpio[g];
  end

  assign tick = (bc_cnt_reg == BC_LAST);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bc_cnt_reg     <= 8'h00;
      lk.bc_gpio     <= 4'h0;
      lk.bc_irq_n    <= 1'b1;
      lk.bc_surround <= 1'b0;
    end else begin
      bc_cnt_reg <= tick ? 8'h00 : bc_cnt_reg + 8'h01;
      if (tick) begin
        lk.bc_gpio     <= bc_c;
        lk.bc_irq_n    <= s2_reg[4];
        lk.bc_surround <= surround_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_out_o   <= 4'h0;
      pin_oe_o    <= 4'h0;
      cfg_18bit_o <= 1'b0;
    end else begin
      pin_out_o   <= out_c;
      pin_oe_o    <= oe_c;
      cfg_18bit_o <= lk.cfg_18bit;
    end
  end

  // Control channel: request held by the host until the ack returns
  assign lk.ctl_req   = host_req_i;
  assign lk.ctl_we    = host_we_i;
  assign lk.ctl_addr  = host_addr_i;
  assign lk.ctl_wdata = host_wdata_i;
  assign host_ack_o   = lk.ctl_ack;
  assign host_rdata_o = lk.ctl_rdata;

  assign aud_valid_o  = lk.aud_valid;
  assign lk.aud_ready = aud_ready_i;
  assign aud_word_o   = lk.aud_data;
endmodule

// ===== test/ssga_link_monitor.sv
/*
  Link checker: control handshake, back-channel pacing, audio stream.
  Assumes one link's interface signals, its clock and its reset.
*/
`timescale 1ns/1ns
module ssga_link_monitor #(
  parameter int FW = ssga_pkg::FW_DEF
) (
  input wire logic          clk_i,
  input wire logic          resetn_i,
  input wire logic          ctl_req,
  input wire logic          ctl_ack,
  input wire logic [3:0]    bc_gpio,
  input wire logic          bc_irq_n,
  input wire logic          aud_valid,
  input wire logic          aud_ready,
  input wire logic [FW-1:0] aud_data
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_ack_needs_req: assert property (ctl_ack |-> $past(ctl_req))
    else $error("ack without request");
  a_ack_one_cycle: assert property (ctl_ack |=> !ctl_ack)
    else $error("ack longer than one cycle");
  a_req_gets_ack: assert property (ctl_req && !ctl_ack |-> ##[1:8] ctl_ack)
    else $error("request not answered");
  a_gpio_tick_paced: assert property ($changed(bc_gpio) |=> $stable(bc_gpio)[*8])
    else $error("pin state faster than back channel");
  a_irq_tick_paced: assert property ($changed(bc_irq_n) |=> $stable(bc_irq_n)[*8])
    else $error("irq state faster than back channel");
  a_aud_word_held: assert property (aud_valid && !aud_ready |=> aud_valid && $stable(aud_data))
    else $error("stalled audio word changed");
  a_aud_lane_set: assert property (aud_valid |-> |aud_data[FW-3:FW-6])
    else $error("audio word without lanes");
  a_surround_island: assert property (aud_valid && |aud_data[FW-3:FW-4] |-> aud_data[FW-1])
    else $error("surround lanes outside island");
endmodule

// ===== test/serializer_sideband_gpio_audio_tb.sv
/*
  Bench for both link ends joined by one interface.
  Assumes the package, interface, FIFO and both end modules.
*/
`timescale 1ns/1ns
module serializer_sideband_gpio_audio_tb;
  localparam int FW = ssga_pkg::FW_DEF;
  logic          clk_i = 0, resetn_i = 0, pd_n = 1, lf = 0, lgc = 0, irq_in_n = 1, sur = 0;
  logic          req = 0, we = 0, hreq = 0, hwe = 0, bclk = 0, ws = 0, ad = 0, ardy = 0;
  logic          ack, hack, rdy_o, av, irq_n, c18;
  logic [7:0]    addr = 0, wd = 0, haddr = 0, hwd = 0, pin_in = 0, rd, hrd, pout, poe, q;
  logic [15:0]   dcfg = 0;
  logic [3:0]    dpin = 0, dout, doe;
  logic [2:0]    rate;
  logic [FW-1:0] aw;
  int            num_errors = 0, samples_checked = 0;
  logic [23:0]   rows [9] = '{24'h0d5a5a, 24'h0e5a5a, 24'h0f5a5a, 24'h105a5a, 24'h115a5a,
                              24'h125e5e, 24'hc65a5a, 24'h1cff00, 24'h55ff00};
  logic [13:0]   modes [6] = '{{1'b0, 8'h0c, 5'h01}, {1'b1, 8'h00, 5'h1f}, {1'b0, 8'h80, 5'h11},
                               {1'b0, 8'h10, 5'h13}, {1'b0, 8'h60, 5'h11}, {1'b0, 8'h08, 5'h1f}};

  `define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", n, e, s); end end

  ssga_link_if #(.FW(FW)) lk ();
  ssga_ser i_ssga_ser (.clk_i(clk_i), .resetn_i(resetn_i), .lk(lk), .power_down_n_i(pd_n),
    .low_freq_mode_i(lf), .legacy_compat_mode_i(lgc), .reg_req_i(req), .reg_we_i(we), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_ack_o(ack), .reg_rdata_o(rd), .pin_in_i(pin_in), .pin_out_o(pout), .pin_oe_o(poe),
    .audio_bclk_i(bclk), .audio_word_select_i(ws), .audio_data_a_i(ad), .audio_data_b_i(ad),
    .audio_data_c_i(ad), .audio_data_d_i(ad), .audio_ready_o(rdy_o), .irq_out_n_o(irq_n),
    .line_rate_mult_o(rate));
  ssga_des #(.FW(FW)) i_ssga_des (.clk_i(clk_i), .resetn_i(resetn_i), .lk(lk), .pin_cfg_i(dcfg),
    .pin_in_i(dpin), .pin_out_o(dout), .pin_oe_o(doe), .remote_irq_in_n_i(irq_in_n), .surround_i(sur),
    .host_req_i(hreq), .host_we_i(hwe), .host_addr_i(haddr), .host_wdata_i(hwd), .host_ack_o(hack),
    .host_rdata_o(hrd), .aud_valid_o(av), .aud_ready_i(ardy), .aud_word_o(aw), .cfg_18bit_o(c18));
  ssga_link_monitor #(.FW(FW)) i_ssga_link_monitor (.clk_i(clk_i), .resetn_i(resetn_i),
    .ctl_req(lk.ctl_req), .ctl_ack(lk.ctl_ack), .bc_gpio(lk.bc_gpio), .bc_irq_n(lk.bc_irq_n),
    .aud_valid(lk.aud_valid), .aud_ready(lk.aud_ready), .aud_data(lk.aud_data));

  always #5 clk_i = ~clk_i;

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Remote side may wait behind a local access, hence the margin
  task automatic rw(input bit rem, input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] r);
    int n;
    n = 0;
    if (rem) begin
      hreq = 1; hwe = w; haddr = a; hwd = d;
    end else begin
      req = 1; we = w; addr = a; wd = d;
    end
    do wt(1); while ((rem ? hack : ack) !== 1'b1 && ++n < 20);
    r = rem ? hrd : rd;
    hreq = 0;
    req = 0;
    if (n >= 20) num_errors++;
    wt(1);
  endtask

  task automatic pdr;
    pd_n = 0;
    wt(4);
    pd_n = 1;
    wt(4);
  endtask

  // bit clock 12.5 MHz
  // One audio word per call: word select flips before the bit clock rises
  task automatic snd;
    ws = ~ws;
    bclk = 0;
    wt(4);
    bclk = 1;
    wt(4);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    end_of_test();
  end

  initial begin
    wt(2);
    `CHK("irq in reset", 1'b1, irq_n)
    `CHK("rate in reset", 3'h1, rate)
    resetn_i = 1;
    wt(3);
    foreach (rows[i]) begin
      rw(0, 1, rows[i][23:16], rows[i][15:8], q);
      rw(0, 0, rows[i][23:16], 8'h00, q);
      `CHK("readback", rows[i][7:0], q)
    end
    `CHK("18-bit sent", 1'b1, c18)
    pdr();
    rw(1, 0, 8'h0d, 8'h00, q);
    `CHK("pd clears", 8'h00, q)
    pin_in = 8'ha1;
    dcfg = 16'h0035;
    dpin = 4'h2;
    rw(0, 1, 8'h0d, 8'h03, q);
    rw(0, 1, 8'h0e, 8'h05, q);
    rw(0, 1, 8'h10, 8'h03, q);
    rw(0, 1, 8'h11, 8'h03, q);
    wt(30);
    `CHK("fwd pin", 2'b11, {dout[0], doe[0]})
    `CHK("back pin", 2'b11, {pout[1], poe[1]})
    rw(0, 0, 8'h1c, 8'h00, q);
    `CHK("pins low", 8'h41, q)
    rw(0, 0, 8'h1d, 8'h00, q);
    `CHK("pins high", 8'h01, q)
    rw(0, 1, 8'h11, 8'h09, q);
    wt(2);
    `CHK("pin8 drive", 2'b11, {pout[7], poe[7]})
    rw(0, 1, 8'hc6, 8'h21, q);
    irq_in_n = 0;
    wt(30);
    `CHK("irq unarmed", 1'b1, irq_n)
    irq_in_n = 1;
    wt(30);
    rw(0, 0, 8'hc7, 8'h00, q);
    irq_in_n = 0;
    wt(30);
    `CHK("irq low", 1'b0, irq_n)
    rw(1, 0, 8'hc7, 8'h00, q);
    `CHK("irq status", 8'h03, q)
    wt(1);
    `CHK("irq cleared", 1'b1, irq_n)
    irq_in_n = 1;
    lf = 1;
    pdr();
    `CHK("lf rate", 3'h4, rate)
    lgc = 1;
    pdr();
    `CHK("legacy rate", 3'h1, rate)
    rw(1, 0, 8'h1c, 8'h00, q);
    `CHK("legacy remote", 8'h00, q)
    lf = 0;
    lgc = 0;
    pin_in = 0;
    dcfg = 0;
    pdr();
    `CHK("normal rate", 3'h1, rate)
    ad = 1;
    repeat (33) snd();
    `CHK("fifo full", 1'b0, rdy_o)
    `CHK("island word", 2'b11, {av, aw[FW-1]})
    ardy = 1;
    wt(40);
    `CHK("drained", 1'b0, av)
    foreach (modes[i]) begin
      ardy = 0;
      sur = modes[i][13];
      rw(0, 1, 8'h04, modes[i][12:5], q);
      wt(10);
      snd();
      wt(4);
      `CHK("lanes", modes[i][4:0], {aw[FW-1], aw[FW-3:FW-6]})
      ardy = 1;
      wt(4);
    end
    rw(0, 1, 8'h11, 8'h01, q);
    ardy = 0;
    snd();
    wt(4);
    `CHK("pad claim", 5'h17, {aw[FW-1], aw[FW-3:FW-6]})
    end_of_test();
  end
endmodule
